// ==== hw/owm_params.svh ====
// Timing constants, register offsets and field layout for the single-wire host controller
`ifndef OWM_PARAMS_SVH
`define OWM_PARAMS_SVH

`define CLK_MHZ 125
`define NS_PER_US 1000
`define CLK_PERIOD_NS 8
// Slot timing in microseconds, then cycles
`define SLOT_US 80
`define SLOT_CYC ((`SLOT_US * `NS_PER_US) / `CLK_PERIOD_NS)
`define WRITE_START_US 6
`define WRITE_START_CYC ((`WRITE_START_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_START_US 2
`define READ_START_CYC ((`READ_START_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Sampled after the latest device drive and before its shortest hold ends
`define READ_SAMPLE_US 15
`define READ_SAMPLE_CYC ((`READ_SAMPLE_US * `NS_PER_US) / `CLK_PERIOD_NS)
`define WRITE_HOLD_US 70
`define WRITE_HOLD_CYC ((`WRITE_HOLD_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVERY_US 5
`define RECOVERY_CYC ((`RECOVERY_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_LOW_US 500
`define RESET_LOW_CYC ((`RESET_LOW_US * `NS_PER_US + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRESENCE_WAIT_US 480
`define PRESENCE_WAIT_CYC ((`PRESENCE_WAIT_US * `NS_PER_US) / `CLK_PERIOD_NS)
`define PRESENCE_WINDOW_US 75
`define PRESENCE_WINDOW_CYC ((`PRESENCE_WINDOW_US * `NS_PER_US) / `CLK_PERIOD_NS)

// Wishbone register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_TXDATA 8'h04
`define REG_RXDATA 8'h08
`define REG_STATUS 8'h0c
`define REG_CRC 8'h10

// Control word fields
`define CTRL_CMD_LSB 0
`define CTRL_CMD_MSB 1
`define CTRL_GO 2
`define CTRL_CRC_CLR 3

// Status word fields
`define ST_BUSY 0
`define ST_PRESENCE 1
`define ST_DONE 2

// Device status memory map
`define DEV_WP_OFFSET 8'h00
`define DEV_REDIR0_OFFSET 8'h01
`define DEV_REDIR3_OFFSET 8'h04
`define DEV_RSVD_A_OFFSET 8'h05
`define DEV_RSVD_B_OFFSET 8'h06
`define DEV_ZERO_OFFSET 8'h07
`define PAGE_BYTES 32
`define REDIR_VALID 8'hff
`define CRC_POLY 8'h8c

`endif

// ==== hw/owm_pkg.sv ====
// Types shared by the single-wire host controller
package owm_pkg;
  typedef enum logic [1:0] {
    CMD_RESET = 2'b00,
    CMD_WRITE = 2'b01,
    CMD_READ = 2'b10,
    CMD_NONE = 2'b11
  } cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RST_LOW = 3'b001,
    ST_RST_WAIT = 3'b010,
    ST_SLOT_LOW = 3'b011,
    ST_SLOT_HOLD = 3'b100,
    ST_RECOVER = 3'b101
  } link_state_t;
endpackage

// ==== hw/owm_crc8.sv ====
// Bit-serial CRC-8 with polynomial x^8 + x^5 + x^4 + 1, fed LSB first
`timescale 1ns/1ns
`include "owm_params.svh"
module owm_crc8 (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bit stream
  input wire logic clear_in,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  // Result
  output logic [7:0] crc_out
);
  logic fb;

  assign fb = crc_out[0] ^ bit_in;

  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      crc_out <= 8'h00;
    end else if (bit_valid_in) begin
      crc_out <= (crc_out >> 1) ^ (fb ? `CRC_POLY : 8'h00);
    end
  end
endmodule

// ==== hw/owm_host.sv ====
// Single-wire host controller: bit slots, reset and presence, under Wishbone control
//
// How it works
// - each slot spans 80 us from its falling edge, inside 60 to 120 us.
// - write slot starts with 6 us low; bit level is set by then.
// - written level holds to 70 us, ending before slot end for recovery.
// - read slot starts with 2 us low, then the line is released.
// - host leaves the line high at least 10 us between slots, covering memory commands.
// - software reads redirection FFh as page data valid.
// - other values mark the page invalid; replacement is the complement.
// - host resets the device with at least 480 us low.
// - link CRCs use polynomial x^8 + x^5 + x^4 + 1.
// - bytes travel least significant bit first.
`timescale 1ns/1ns
`include "owm_params.svh"
module owm_host (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Open-drain data line
  input wire logic DQ_IN,
  output logic DQ_OUT,
  output logic DQ_OE_OUT,
  // Helpers for software: redirection decode of the last RX byte
  output logic REDIR_VALID_OUT,
  output logic [7:0] REDIR_TARGET_OUT
);
  owm_pkg::link_state_t state;
  owm_pkg::cmd_t cmd;
  logic [16:0] timer;
  logic [2:0] bit_idx;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic presence;
  logic done;
  logic dq_meta;
  logic dq_sync;
  logic wb_req;
  logic go;
  logic crc_clr;
  logic slot_bit;
  logic drive_low;
  logic sample_now;
  logic [7:0] crc_val;
  logic [31:0] next_rdata;

  assign wb_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  assign go = wb_req && WB_WE_IN && (WB_ADR_IN == `REG_CTRL) && WB_SEL_IN[0]
              && WB_DAT_IN[`CTRL_GO] && (state == owm_pkg::ST_IDLE);
  assign crc_clr = wb_req && WB_WE_IN && (WB_ADR_IN == `REG_CTRL) && WB_SEL_IN[0]
                   && WB_DAT_IN[`CTRL_CRC_CLR];
  assign slot_bit = tx_byte[bit_idx];
  assign sample_now = (state == owm_pkg::ST_SLOT_HOLD) && (cmd == owm_pkg::CMD_READ)
                      && (timer == 17'(`READ_SAMPLE_CYC));

  // Two flops before any logic sees the pin
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      dq_meta <= 1'b1;
      dq_sync <= 1'b1;
    end else begin
      dq_meta <= DQ_IN;
      dq_sync <= dq_meta;
    end
  end

  // Wishbone acknowledge: one cycle after the strobe, dropped the cycle after
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      WB_ACK_OUT <= 1'b0;
    end else begin
      WB_ACK_OUT <= wb_req;
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (WB_ADR_IN)
      `REG_CTRL: next_rdata = {30'h0000_0000, cmd};
      `REG_TXDATA: next_rdata = {24'h00_0000, tx_byte};
      `REG_RXDATA: next_rdata = {24'h00_0000, rx_byte};
      `REG_STATUS: next_rdata = {29'h0000_0000, done, presence, state != owm_pkg::ST_IDLE};
      `REG_CRC: next_rdata = {24'h00_0000, crc_val};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      WB_DAT_OUT <= 32'h0000_0000;
    end else if (wb_req && !WB_WE_IN) begin
      WB_DAT_OUT <= next_rdata;
    end
  end

  // Command and transmit byte; rejected while a slot is running
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      cmd <= owm_pkg::CMD_NONE;
      tx_byte <= 8'h00;
    end else begin
      if (go) begin
        cmd <= owm_pkg::cmd_t'(WB_DAT_IN[`CTRL_CMD_MSB:`CTRL_CMD_LSB]);
      end
      if (wb_req && WB_WE_IN && (WB_ADR_IN == `REG_TXDATA) && WB_SEL_IN[0]
          && (state == owm_pkg::ST_IDLE)) begin
        tx_byte <= WB_DAT_IN[7:0];
      end
    end
  end

  // Link sequencer
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state <= owm_pkg::ST_IDLE;
      timer <= 17'h0_0000;
      bit_idx <= 3'h0;
    end else begin
      timer <= timer + 17'h0_0001;
      unique case (state)
        owm_pkg::ST_IDLE: begin
          timer <= 17'h0_0000;
          bit_idx <= 3'h0;
          if (go) begin
            if (owm_pkg::cmd_t'(WB_DAT_IN[`CTRL_CMD_MSB:`CTRL_CMD_LSB]) == owm_pkg::CMD_RESET) begin
              state <= owm_pkg::ST_RST_LOW;
            end else if (owm_pkg::cmd_t'(WB_DAT_IN[`CTRL_CMD_MSB:`CTRL_CMD_LSB])
                         != owm_pkg::CMD_NONE) begin
              state <= owm_pkg::ST_SLOT_LOW;
            end
          end
        end
        owm_pkg::ST_RST_LOW: begin
          if (timer == 17'(`RESET_LOW_CYC - 1)) begin
            state <= owm_pkg::ST_RST_WAIT;
            timer <= 17'h0_0000;
          end
        end
        owm_pkg::ST_RST_WAIT: begin
          // Long enough to cover the latest presence pulse end
          if (timer == 17'(`PRESENCE_WAIT_CYC - 1)) begin
            state <= owm_pkg::ST_IDLE;
          end
        end
        owm_pkg::ST_SLOT_LOW: begin
          if ((cmd == owm_pkg::CMD_WRITE && timer == 17'(`WRITE_START_CYC - 1)) ||
              (cmd == owm_pkg::CMD_READ && timer == 17'(`READ_START_CYC - 1))) begin
            state <= owm_pkg::ST_SLOT_HOLD;
          end
        end
        owm_pkg::ST_SLOT_HOLD: begin
          if (timer == 17'(`WRITE_HOLD_CYC - 1)) begin
            state <= owm_pkg::ST_RECOVER;
          end
        end
        owm_pkg::ST_RECOVER: begin
          // Slot length includes recovery, so the next edge lands at 80 us
          if (timer == 17'(`SLOT_CYC - 1)) begin
            timer <= 17'h0_0000;
            bit_idx <= bit_idx + 3'h1;
            state <= (bit_idx == 3'h7) ? owm_pkg::ST_IDLE : owm_pkg::ST_SLOT_LOW;
          end
        end
        default: state <= owm_pkg::ST_IDLE;
      endcase
    end
  end

  // Presence is seen if the line is low at the single sample 75 us after reset release
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      presence <= 1'b0;
    end else if (state == owm_pkg::ST_RST_LOW) begin
      presence <= 1'b0;
    end else if (state == owm_pkg::ST_RST_WAIT && timer == 17'(`PRESENCE_WINDOW_CYC)) begin
      presence <= !dq_sync;
    end
  end

  // Receive byte, LSB first
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rx_byte <= 8'h00;
    end else if (sample_now) begin
      rx_byte <= {dq_sync, rx_byte[7:1]};
    end
  end

  // Done is sticky until a GO write clears it, including one with CMD_NONE that starts nothing
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      done <= 1'b0;
    end else if (state != owm_pkg::ST_IDLE && (
                 (state == owm_pkg::ST_RST_WAIT && timer == 17'(`PRESENCE_WAIT_CYC - 1)) ||
                 (state == owm_pkg::ST_RECOVER && timer == 17'(`SLOT_CYC - 1)
                  && bit_idx == 3'h7))) begin
      done <= 1'b1;
    end else if (go) begin
      done <= 1'b0;
    end
  end

  // Drive low at slot start; during a write hold, low only for a zero bit
  always_comb begin
    drive_low = 1'b0;
    unique case (state)
      owm_pkg::ST_RST_LOW: drive_low = 1'b1;
      owm_pkg::ST_SLOT_LOW: drive_low = 1'b1;
      owm_pkg::ST_SLOT_HOLD: drive_low = (cmd == owm_pkg::CMD_WRITE) && !slot_bit;
      default: drive_low = 1'b0;
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      DQ_OE_OUT <= 1'b0;
      DQ_OUT <= 1'b1;
    end else begin
      DQ_OE_OUT <= drive_low;
      DQ_OUT <= 1'b0;
    end
  end

  // Running CRC over every bit moved on the link
  owm_crc8 crc_unit (
    .clk_in(SYS_CLK_IN),
    .rst_in(RST_IN),
    .clear_in(crc_clr),
    .bit_valid_in(sample_now || (state == owm_pkg::ST_RECOVER && cmd == owm_pkg::CMD_WRITE
                  && timer == 17'(`SLOT_CYC - 1))),
    .bit_in(cmd == owm_pkg::CMD_READ ? dq_sync : slot_bit),
    .crc_out(crc_val)
  );

  // Software aid: FFh means valid, else target page is the complement
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      REDIR_VALID_OUT <= 1'b1;
      REDIR_TARGET_OUT <= 8'h00;
    end else begin
      REDIR_VALID_OUT <= (rx_byte == `REDIR_VALID);
      REDIR_TARGET_OUT <= ~rx_byte;
    end
  end
endmodule

// ==== tb/owm_host_chk.sv ====
// Concurrent checks on the host controller's bus and line timing
`timescale 1ns/1ns
module owm_host_chk (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Line
  input wire logic DQ_OE_OUT,
  input wire logic REDIR_VALID_OUT,
  input wire logic [7:0] REDIR_TARGET_OUT
);
  logic [16:0] low_cnt;
  logic [16:0] high_cnt;
  logic [16:0] period_cnt;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  // High and period counters saturate, so the long idle before the first slot never wraps
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      low_cnt <= 17'h00000;
      high_cnt <= 17'h1ffff;
      period_cnt <= 17'h1ffff;
    end else begin
      low_cnt <= DQ_OE_OUT ? low_cnt + 17'h00001 : 17'h00000;
      high_cnt <= DQ_OE_OUT ? 17'h00000 : high_cnt + {16'h0000, high_cnt != 17'h1ffff};
      period_cnt <= $rose(DQ_OE_OUT) ? 17'h00001 :
                    period_cnt + {16'h0000, period_cnt != 17'h1ffff};
    end
  end
  sequence bus_req;
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
  endsequence
  sequence ack_pulse;
    WB_ACK_OUT ##1 !WB_ACK_OUT;
  endsequence
  ack_timing_a: assert property (bus_req |=> ack_pulse)
    else $error("ack not a single pulse after request");
  ack_cause_a: assert property (WB_ACK_OUT |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");
  unmapped_zero_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_WE_IN &&
    WB_ADR_IN == 8'h14 |=> WB_DAT_OUT == 32'h00000000)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!(WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && !WB_WE_IN)
    |=> $stable(WB_DAT_OUT))
    else $error("read data changed without read");
  slot_low_a: assert property ($fell(DQ_OE_OUT) |-> low_cnt inside
    {[17'h0007d:17'h00753], [17'h01d4c:17'h0270f], [17'h0ea60:17'h11170]})
    else $error("low phase length out of range");
  start_low_a: assert property ($rose(DQ_OE_OUT) |-> DQ_OE_OUT [*8])
    else $error("low phase shorter than eight cycles");
  line_recovery_a: assert property ($rose(DQ_OE_OUT) |-> high_cnt >= 17'h00271)
    else $error("recovery too short");
  slot_period_a: assert property ($rose(DQ_OE_OUT) |-> period_cnt >= 17'h01d4c)
    else $error("slot shorter than minimum");
  redir_code_a: assert property (bus_req and !WB_WE_IN && WB_ADR_IN == 8'h08 |=>
    REDIR_TARGET_OUT == ~WB_DAT_OUT[7:0] && REDIR_VALID_OUT == (WB_DAT_OUT[7:0] == 8'hff))
    else $error("redirection decode inconsistent");
endmodule
bind owm_host owm_host_chk owm_host_chk_inst (.SYS_CLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_WE_IN, .WB_ADR_IN, .WB_DAT_OUT, .WB_ACK_OUT, .DQ_OE_OUT, .REDIR_VALID_OUT,
  .REDIR_TARGET_OUT);

// ==== tb/owm_dev_model.sv ====
// Behavioural memory device on the pulled-up single-wire line
`timescale 1ns/1ns
module owm_dev_model (
  input wire logic line_in,
  output logic pull_out,
  output logic [7:0] rx_byte_out
);
  time t_fall = 0;
  time width;
  int slot = 0;
  logic [7:0] status_mem [0:7];
  logic [7:0] tx_byte;
  initial begin
    pull_out = 1'b0;
    rx_byte_out = 8'h00;
    status_mem[0] = 8'h11; // Page 0 protected and marked used
    status_mem[1] = 8'hfd; // Page 0 moved to page 2
    status_mem[2] = 8'hff;
    status_mem[3] = 8'hff;
    status_mem[4] = 8'hff;
    status_mem[5] = 8'hff; // Reserved bytes are plain storage
    status_mem[6] = 8'hff;
    status_mem[7] = 8'h00;
  end
  // Own pulls are ignored so presence never looks like a host slot
  always @(negedge line_in) begin
    if (!pull_out) begin
      t_fall = $time;
      // Read slots serve the redirection bytes as stored; nothing acts on them
      if (slot >= 8 && slot < 64) begin
        tx_byte = status_mem[(slot - 8) / 8 + 1];
      end else begin
        tx_byte = 8'hff;
      end
      if (slot >= 8 && !tx_byte[(slot - 8) % 8]) begin
        // Latest allowed drive and shortest hold, so an early host sample misses it
        #13000 pull_out = 1'b1;
        #17000 pull_out = 1'b0;
      end else begin
        #30000 if (slot < 8) rx_byte_out[slot] = line_in;
      end
      slot++;
    end
  end
  always @(posedge line_in) begin
    width = $time - t_fall;
    t_fall = $time;
    if (!pull_out && width >= 480000) begin
      slot = 0;
      #30000 pull_out = 1'b1;
      #120000 pull_out = 1'b0;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the single-wire host controller
`timescale 1ns/1ns
`include "owm_params.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  wire logic [31:0] dat_out;
  wire logic ack, dq_out, dq_oe, rv, line, pull;
  wire logic [7:0] rt, dev_rx;
  int n_fail = 0;
  int tests_run = 0;
  assign line = !dq_oe && !pull;
  always #4 clk = !clk;
  owm_host owm_host_inst (.SYS_CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'h1), .WB_DAT_IN(wdat), .WB_DAT_OUT(dat_out),
    .WB_ACK_OUT(ack), .DQ_IN(line), .DQ_OUT(dq_out), .DQ_OE_OUT(dq_oe),
    .REDIR_VALID_OUT(rv), .REDIR_TARGET_OUT(rt));
  owm_dev_model owm_dev_model_inst (.line_in(line), .pull_out(pull), .rx_byte_out(dev_rx));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rdat = dat_out;
    check("bus ack", {31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 200; i++) begin
      wb(1'b0, `REG_STATUS, 32'h0);
      if (rdat[`ST_DONE] === 1'b1) break;
      repeat (1000) @(posedge clk);
    end
    check("done", {31'h0, rdat[`ST_DONE]}, 32'h1);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] b);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 8; i++) c = (c >> 1) ^ ((c[0] ^ b[i]) ? 8'h8c : 8'h00);
    return c;
  endfunction
  task automatic t_reset();
    wb(1'b1, `REG_CTRL, 32'h00000004);
    wait_done();
    check("presence", {31'h0, rdat[`ST_PRESENCE]}, 32'h1);
    check("busy", {31'h0, rdat[`ST_BUSY]}, 32'h0);
    check("line data level", {31'h0, dq_out}, 32'h0);
    $display("test reset finished");
  endtask
  task automatic t_write();
    wb(1'b1, `REG_TXDATA, 32'h000000a5);
    wb(1'b1, `REG_CTRL, 32'h00000005);
    // Refused while busy: the byte on the wire must stay a5
    wb(1'b1, `REG_TXDATA, 32'h0000003c);
    wait_done();
    check("received byte", {24'h0, dev_rx}, 32'h000000a5);
    $display("test write finished");
  endtask
  task automatic t_read();
    wb(1'b1, `REG_CTRL, 32'h0000000b);
    wb(1'b1, `REG_CTRL, 32'h00000006);
    wait_done();
    wb(1'b0, `REG_RXDATA, 32'h0);
    check("read byte", {24'h0, rdat[7:0]}, 32'h000000fd);
    wb(1'b0, `REG_CRC, 32'h0);
    check("crc", {24'h0, rdat[7:0]}, {24'h0, crc8(8'hfd)});
    check("redir valid", {31'h0, rv}, 32'h0);
    check("redir target", {24'h0, rt}, 32'h00000002);
    wb(1'b0, 8'h14, 32'h0);
    check("unmapped", rdat, 32'h00000000);
    wb(1'b0, `REG_CTRL, 32'h0);
    check("ctrl cmd", {30'h0, rdat[1:0]}, 32'h00000002);
    // Next byte is an untouched redirection byte, the only way to see a valid page
    wb(1'b1, `REG_CTRL, 32'h00000006);
    wait_done();
    wb(1'b0, `REG_RXDATA, 32'h0);
    check("second read byte", {24'h0, rdat[7:0]}, 32'h000000ff);
    check("redir valid ff", {31'h0, rv}, 32'h1);
    check("redir target ff", {24'h0, rt}, 32'h00000000);
    $display("test read finished");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #5000000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_write();
    t_read();
    conclude();
  end
endmodule
